// ==== design/ppcfg_pkg.sv ====
// register map, field layout and reset values of the port M / port P pin configuration block
// assumes a 32-bit APB with each register on an aligned word (byte address = 4 * index)
package ppcfg_pkg;

    localparam int unsigned ADDR_W = 12;
    localparam int unsigned DATA_W = 32;
    localparam int unsigned PM_W   = 8;
    localparam int unsigned PP_W   = 6;

    // register indices; byte address is four times the index
    localparam logic [9:0] IDX_M_DIRECTION     = 10'h012;
    localparam logic [9:0] IDX_M_REDUCED_DRIVE = 10'h013;
    localparam logic [9:0] IDX_M_PULL_ENABLE   = 10'h014;
    localparam logic [9:0] IDX_M_PULL_POLARITY = 10'h015;
    localparam logic [9:0] IDX_M_OPEN_DRAIN    = 10'h016;
    localparam logic [9:0] IDX_P_DATA          = 10'h018;
    localparam logic [9:0] IDX_P_PIN_LEVEL     = 10'h019;
    localparam logic [9:0] IDX_P_DIRECTION     = 10'h01A;

    // implemented bits: port M bit 2 does not exist
    localparam logic [7:0] PM_IMPL_MASK = 8'hFB;
    localparam logic [5:0] PP_IMPL_MASK = 6'h3F;

    // port M pin roles
    localparam int unsigned PM_SCL_BIT = 7;
    localparam int unsigned PM_SDA_BIT = 6;
    localparam int unsigned PM_TX_BIT  = 5;
    localparam int unsigned PM_RX_BIT  = 4;
    localparam int unsigned PM_DA1_BIT = 1;
    localparam int unsigned PM_DA0_BIT = 0;

    // reset values
    localparam logic [7:0] PM_DIRECTION_RST     = 8'h00;
    localparam logic [7:0] PM_REDUCED_DRIVE_RST = 8'h00;
    localparam logic [7:0] PM_PULL_ENABLE_RST   = 8'hF0;
    localparam logic [7:0] PM_PULL_POLARITY_RST = 8'h00;
    localparam logic [7:0] PM_OPEN_DRAIN_RST    = 8'h00;
    localparam logic [5:0] PP_DATA_RST          = 6'h00;
    localparam logic [5:0] PP_DIRECTION_RST     = 6'h00;

endpackage

// ==== design/ppcfg_port_cfg.sv ====
// pin configuration and ownership multiplexing for port M (8 pins) and port P (6 pins)
// assumes an APB master on clk_i; pins arrive asynchronously; peripheral signals share clk_i
//
// Implementation choice: register access over APB.
`timescale 1ns/1ps

// Functional notes
// - port M direction bits 7:3,1:0; 1=output
// - enabled I2C owns direction of pins 7:6
// - enabled serial transmitter owns pin 5 direction
// - enabled serial receiver owns pin 4 direction
// - enabled DAC forces pin 1/0 output
// - overrides never alter stored direction bits
// - reduced-drive bit applies to outputs only
// - pull enable for inputs and open-drain outputs
// - polarity 0 up, 1 down, inputs only
// - open-drain drives low only, ignored on inputs
// - open-drain selection also covers serial transmit
// - I2C pins always open-drain, bits untouched
// - enabled PWM channel drives its port P pin
// - port P data reads register or pin
// - pin-level register read-only, writes discarded
// - port P pins high-impedance inputs in reset
// - port P direction bits 5:0; 1=output
// - configuration registers readable and writable anytime
// - reset: pins 7:4 pulled up, others floating
module ppcfg_port_cfg
    import ppcfg_pkg::*;
(
    input  wire logic                clk_i,
    input  wire logic                reset_i,
    input  wire logic                psel_i,
    input  wire logic                penable_i,
    input  wire logic                pwrite_i,
    input  wire logic [ADDR_W-1:0]   paddr_i,
    input  wire logic [DATA_W-1:0]   pwdata_i,
    output logic      [DATA_W-1:0]   prdata_o,
    output logic                     pready_o,
    output logic                     pslverr_o,
    input  wire logic [PM_W-1:0]     port_m_data_i,
    input  wire logic                iic_enable_i,
    input  wire logic [1:0]          iic_dir_i,
    input  wire logic [1:0]          iic_out_i,
    input  wire logic                sci_tx_enable_i,
    input  wire logic                sci_tx_i,
    input  wire logic                sci_rx_enable_i,
    input  wire logic [1:0]          dac_enable_i,
    input  wire logic [PP_W-1:0]     pwm_enable_i,
    input  wire logic [PP_W-1:0]     pwm_i,
    input  wire logic [PM_W-1:0]     pm_pin_i,
    output logic      [PM_W-1:0]     pm_pin_o,
    output logic      [PM_W-1:0]     pm_pin_oe_o,
    output logic      [PM_W-1:0]     pm_pull_enable_o,
    output logic      [PM_W-1:0]     pm_pull_down_o,
    output logic      [PM_W-1:0]     pm_reduced_drive_o,
    output logic      [PM_W-1:0]     pm_level_o,
    input  wire logic [PP_W-1:0]     pp_pin_i,
    output logic      [PP_W-1:0]     pp_pin_o,
    output logic      [PP_W-1:0]     pp_pin_oe_o,
    output logic      [PP_W-1:0]     pp_level_o
);

    logic [7:0]      m_dir_q;
    logic [7:0]      m_rdr_q;
    logic [7:0]      m_pe_q;
    logic [7:0]      m_pps_q;
    logic [7:0]      m_od_q;
    logic [5:0]      p_data_q;
    logic [5:0]      p_dir_q;
    logic [DATA_W-1:0] prdata_q;

    logic [9:0]      idx;
    logic            hit;
    logic            wr_en;
    logic [7:0]      wbyte;
    logic [7:0]      rd_d;

    // masks, pin roles and reset values are laid out for 8 port M and 6 port P pins
    if (PM_W != 8 || PP_W != 6) begin : g_width_chk
        $error("pin counts do not match the register layout");
    end

    // ---------------- APB slave: zero wait states ----------------
    assign idx   = paddr_i[ADDR_W-1:2];
    assign wbyte = pwdata_i[7:0];
    always_comb begin
        hit = 1'b1;
        case (idx)
            IDX_M_DIRECTION, IDX_M_REDUCED_DRIVE, IDX_M_PULL_ENABLE,
            IDX_M_PULL_POLARITY, IDX_M_OPEN_DRAIN, IDX_P_DATA,
            IDX_P_PIN_LEVEL, IDX_P_DIRECTION: hit = 1'b1;
            default: hit = 1'b0;
        endcase
    end
    assign pready_o  = 1'b1;
    assign pslverr_o = psel_i & penable_i & ~hit;
    assign wr_en     = psel_i & penable_i & pwrite_i & hit;

    // ---------------- pin input synchronisers ----------------
    logic [7:0] m_s1_q;
    logic [7:0] m_s2_q;
    logic [7:0] m_s3_q;
    logic [7:0] m_lvl_q;
    logic [5:0] p_s1_q;
    logic [5:0] p_s2_q;
    logic [5:0] p_s3_q;
    logic [5:0] p_lvl_q;

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            m_s1_q <= 8'h00;
            m_s2_q <= 8'h00;
            m_s3_q <= 8'h00;
            p_s1_q <= 6'h00;
            p_s2_q <= 6'h00;
            p_s3_q <= 6'h00;
        end else begin
            m_s1_q <= pm_pin_i;
            m_s2_q <= m_s1_q;
            m_s3_q <= m_s2_q;
            p_s1_q <= pp_pin_i;
            p_s2_q <= p_s1_q;
            p_s3_q <= p_s2_q;
        end
    end

    // a level change is accepted once stages two and three agree
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            m_lvl_q <= 8'h00;
            p_lvl_q <= 6'h00;
        end else begin
            m_lvl_q <= ((m_s2_q ~^ m_s3_q) & m_s3_q) | ((m_s2_q ^ m_s3_q) & m_lvl_q);
            p_lvl_q <= ((p_s2_q ~^ p_s3_q) & p_s3_q) | ((p_s2_q ^ p_s3_q) & p_lvl_q);
        end
    end
    assign pm_level_o = m_lvl_q & PM_IMPL_MASK;
    assign pp_level_o = p_lvl_q;

    // ---------------- configuration registers ----------------
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            m_dir_q <= PM_DIRECTION_RST;
            m_rdr_q <= PM_REDUCED_DRIVE_RST;
            m_pe_q  <= PM_PULL_ENABLE_RST;
            m_pps_q <= PM_PULL_POLARITY_RST;
            m_od_q  <= PM_OPEN_DRAIN_RST;
        end else if (wr_en) begin
            // peripheral enables never touch these bits
            case (idx)
                IDX_M_DIRECTION:     m_dir_q <= wbyte & PM_IMPL_MASK;
                IDX_M_REDUCED_DRIVE: m_rdr_q <= wbyte & PM_IMPL_MASK;
                IDX_M_PULL_ENABLE:   m_pe_q  <= wbyte & PM_IMPL_MASK;
                IDX_M_PULL_POLARITY: m_pps_q <= wbyte & PM_IMPL_MASK;
                IDX_M_OPEN_DRAIN:    m_od_q  <= wbyte & PM_IMPL_MASK;
                default: ;
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            p_data_q <= PP_DATA_RST;
            p_dir_q  <= PP_DIRECTION_RST;
        end else if (wr_en) begin
            case (idx)
                IDX_P_DATA:      p_data_q <= wbyte[5:0];
                IDX_P_DIRECTION: p_dir_q  <= wbyte[5:0];
                default: ;
            endcase
        end
    end

    // ---------------- read path: sampled in the setup cycle ----------------
    always_comb begin
        case (idx)
            IDX_M_DIRECTION:     rd_d = m_dir_q;
            IDX_M_REDUCED_DRIVE: rd_d = m_rdr_q;
            IDX_M_PULL_ENABLE:   rd_d = m_pe_q;
            IDX_M_PULL_POLARITY: rd_d = m_pps_q;
            IDX_M_OPEN_DRAIN:    rd_d = m_od_q;
            IDX_P_DATA:          rd_d = {2'b00, (p_data_q & p_dir_q) | (p_lvl_q & ~p_dir_q)};
            IDX_P_PIN_LEVEL:     rd_d = {2'b00, p_lvl_q};
            IDX_P_DIRECTION:     rd_d = {2'b00, p_dir_q};
            default:             rd_d = 8'h00;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            prdata_q <= 32'h0000_0000;
        end else if (psel_i & ~penable_i) begin
            prdata_q <= {24'h00_0000, rd_d};
        end
    end
    assign prdata_o = prdata_q;

    // ---------------- port M ownership ----------------
    logic [7:0] m_dir_eff;
    logic [7:0] m_val_eff;
    logic [7:0] m_od_eff;
    logic [7:0] m_out_d;
    logic [7:0] m_oe_d;
    logic [7:0] m_pe_d;
    logic [7:0] m_pd_d;
    logic [7:0] m_rd_d;
    logic [7:0] m_pushpull;

    always_comb begin
        m_dir_eff = m_dir_q;
        m_val_eff = port_m_data_i;
        m_od_eff  = m_od_q;
        if (iic_enable_i) begin
            m_dir_eff[PM_SCL_BIT] = iic_dir_i[1];
            m_dir_eff[PM_SDA_BIT] = iic_dir_i[0];
            m_val_eff[PM_SCL_BIT] = iic_out_i[1];
            m_val_eff[PM_SDA_BIT] = iic_out_i[0];
            m_od_eff[PM_SCL_BIT]  = 1'b1;
            m_od_eff[PM_SDA_BIT]  = 1'b1;
        end
        if (sci_tx_enable_i) begin
            m_dir_eff[PM_TX_BIT] = 1'b1;
            m_val_eff[PM_TX_BIT] = sci_tx_i;
        end
        if (sci_rx_enable_i) begin
            m_dir_eff[PM_RX_BIT] = 1'b0;
        end
        if (dac_enable_i[1]) begin
            m_dir_eff[PM_DA1_BIT] = 1'b1;
            m_val_eff[PM_DA1_BIT] = 1'b0;
        end
        if (dac_enable_i[0]) begin
            m_dir_eff[PM_DA0_BIT] = 1'b1;
            m_val_eff[PM_DA0_BIT] = 1'b0;
        end
        m_dir_eff = m_dir_eff & PM_IMPL_MASK;
    end

    // per-pin driver, pull and drive-strength decision
    genvar gi;
    generate
        for (gi = 0; gi < PM_W; gi++) begin : g_pm
            always_comb begin
                if (m_dir_eff[gi] && m_od_eff[gi]) begin
                    m_out_d[gi] = 1'b0;
                    m_oe_d[gi]  = ~m_val_eff[gi];
                end else begin
                    m_out_d[gi] = m_val_eff[gi];
                    m_oe_d[gi]  = m_dir_eff[gi];
                end
                m_pe_d[gi] = m_pe_q[gi] & (~m_dir_eff[gi] | m_od_eff[gi]);
                m_pd_d[gi] = m_pps_q[gi] & m_pe_q[gi] & ~m_dir_eff[gi];
                m_rd_d[gi] = m_rdr_q[gi] & m_dir_eff[gi];
            end
        end
    endgenerate

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            pm_pin_o           <= 8'h00;
            pm_pin_oe_o        <= 8'h00;
            pm_pull_enable_o   <= PM_PULL_ENABLE_RST;
            pm_pull_down_o     <= 8'h00;
            pm_reduced_drive_o <= 8'h00;
        end else begin
            pm_pin_o           <= m_out_d & PM_IMPL_MASK;
            pm_pin_oe_o        <= m_oe_d & PM_IMPL_MASK;
            pm_pull_enable_o   <= m_pe_d & PM_IMPL_MASK;
            pm_pull_down_o     <= m_pd_d & PM_IMPL_MASK;
            pm_reduced_drive_o <= m_rd_d & PM_IMPL_MASK;
        end
    end

    // ---------------- port P ownership ----------------
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            pp_pin_o    <= 6'h00;
            pp_pin_oe_o <= 6'h00;
        end else begin
            pp_pin_o    <= (pwm_enable_i & pwm_i) | (~pwm_enable_i & p_data_q);
            pp_pin_oe_o <= pwm_enable_i | p_dir_q;
        end
    end

    // ---------------- checks ----------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (reset_i);
    // pins driven push-pull in this cycle, for the pull check
    assign m_pushpull = m_dir_eff & ~m_od_eff;

    chk_iic_open_drain: assert property (
        iic_enable_i |=> !(pm_pin_oe_o[PM_SCL_BIT] && pm_pin_o[PM_SCL_BIT])
            && !(pm_pin_oe_o[PM_SDA_BIT] && pm_pin_o[PM_SDA_BIT]))
        else $error("i2c pin driven high");
    chk_iic_dir_own: assert property (
        iic_enable_i && !iic_dir_i[1] |=> !pm_pin_oe_o[PM_SCL_BIT])
        else $error("i2c input pin driven");
    chk_tx_dir_own: assert property (
        sci_tx_enable_i && !(m_od_q[PM_TX_BIT] && sci_tx_i) |=> pm_pin_oe_o[PM_TX_BIT])
        else $error("transmit pin not driven");
    chk_rx_dir_own: assert property (
        sci_rx_enable_i |=> !pm_pin_oe_o[PM_RX_BIT])
        else $error("receive pin driven");
    chk_dac_force_out: assert property (
        dac_enable_i[1] |=> pm_pin_oe_o[PM_DA1_BIT])
        else $error("dac pin not output");
    chk_dir_kept: assert property (
        !wr_en |=> $stable(m_dir_q) && $stable(m_od_q))
        else $error("direction changed without write");
    chk_od_low_only: assert property (
        m_dir_eff[3] && m_od_eff[3] |=> !pm_pin_o[3])
        else $error("open drain pin driven high");
    chk_pull_push_pull: assert property (
        m_pushpull != 8'h00 |=> (pm_pull_enable_o & $past(m_pushpull)) == 8'h00)
        else $error("pull on push-pull output");
    chk_pwm_own: assert property (
        pwm_enable_i[0] |=> pp_pin_oe_o[0] && pp_pin_o[0] == $past(pwm_i[0]))
        else $error("pwm pin not owned");
    chk_lvl_ro: assert property (
        wr_en && idx == IDX_P_PIN_LEVEL |=> $stable(p_data_q) && $stable(p_dir_q))
        else $error("pin level write had effect");
    chk_pdata_read: assert property (
        psel_i && !penable_i && idx == IDX_P_DATA |=> prdata_o[5:0] ==
            (($past(p_data_q) & $past(p_dir_q)) | ($past(p_lvl_q) & ~$past(p_dir_q))))
        else $error("port p data read wrong");
    chk_reset_state: assert property (
        disable iff (1'b0) $fell(reset_i) |-> pm_pull_enable_o == PM_PULL_ENABLE_RST
            && pm_pin_oe_o == 8'h00 && pp_pin_oe_o == 6'h00)
        else $error("reset pin state wrong");

    // pin behaviour checks
    chk_dac0_force_out: assert property (
        dac_enable_i[0] |=> pm_pin_oe_o[PM_DA0_BIT] && !pm_pin_o[PM_DA0_BIT])
        else $error("dac pin not driven low");
    chk_tx_value: assert property (
        sci_tx_enable_i && !m_od_q[PM_TX_BIT] |=> pm_pin_o[PM_TX_BIT] == $past(sci_tx_i))
        else $error("transmit value not passed");
    chk_tx_open_drain: assert property (
        sci_tx_enable_i && m_od_q[PM_TX_BIT] && sci_tx_i |=> !pm_pin_oe_o[PM_TX_BIT])
        else $error("open drain transmit driven high");
    chk_od_never_high: assert property (
        (pm_pin_o & pm_pin_oe_o & $past(m_od_eff) & $past(m_dir_eff)) == 8'h00)
        else $error("open drain output driven high");
    chk_rdr_outputs_only: assert property (
        (pm_reduced_drive_o & ~$past(m_dir_eff)) == 8'h00)
        else $error("reduced drive on input pin");
    chk_pull_on_input: assert property (
        (~$past(m_dir_eff) & $past(m_pe_q) & ~pm_pull_enable_o) == 8'h00)
        else $error("pull missing on input pin");
    chk_pull_down_input: assert property (
        (pm_pull_down_o & ($past(m_dir_eff) | ~$past(m_pe_q))) == 8'h00)
        else $error("pull down outside enabled input");
    chk_pwm_released: assert property (
        !pwm_enable_i[1] |=> pp_pin_oe_o[1] == $past(p_dir_q[1])
            && pp_pin_o[1] == $past(p_data_q[1]))
        else $error("port p pin not back under gpio");

    // register and reset checks
    chk_mdir_write: assert property (
        wr_en && idx == IDX_M_DIRECTION |=> m_dir_q == ($past(wbyte) & PM_IMPL_MASK))
        else $error("direction write lost");
    chk_pdata_write: assert property (
        wr_en && idx == IDX_P_DATA |=> p_data_q == $past(wbyte[5:0]))
        else $error("port p data write lost");
    chk_pdir_write: assert property (
        wr_en && idx == IDX_P_DIRECTION |=> p_dir_q == $past(wbyte[5:0]))
        else $error("port p direction write lost");
    chk_level_read: assert property (
        psel_i && !penable_i && idx == IDX_P_PIN_LEVEL |=> prdata_o[5:0] == $past(p_lvl_q))
        else $error("pin level read wrong");
    chk_p_reset_input: assert property (
        disable iff (1'b0) reset_i |=> pp_pin_oe_o == 6'h00 && pp_pin_o == 6'h00)
        else $error("port p pin driven in reset");
    chk_m_reset_pull: assert property (
        disable iff (1'b0) reset_i |=> pm_pull_enable_o == PM_PULL_ENABLE_RST
            && pm_pull_down_o == 8'h00 && pm_pin_oe_o == 8'h00)
        else $error("port m reset pins wrong");

endmodule

// ==== tb/ppcfg_pin_model.sv ====
// pad model for ports M and P: resolves each pad from device and outside driver, and each port M pad also from its pull
// assumes device outputs are registered on clk_i; a floating pad changes every cycle
`timescale 1ns/1ps
module ppcfg_pin_model (
    input  wire logic       clk_i,
    input  wire logic [7:0] pm_val_i,
    input  wire logic [7:0] pm_oe_i,
    input  wire logic [7:0] pm_pull_i,
    input  wire logic [7:0] pm_down_i,
    input  wire logic [5:0] pp_val_i,
    input  wire logic [5:0] pp_oe_i,
    input  wire logic [7:0] ext_pm_i,
    input  wire logic [7:0] ext_pm_en_i,
    input  wire logic [5:0] ext_pp_i,
    input  wire logic [5:0] ext_pp_en_i,
    output logic      [7:0] pm_pad_o,
    output logic      [5:0] pp_pad_o
);
    logic [7:0] float_q = 8'h55;

    always @(posedge clk_i) begin
        float_q <= ~float_q;
    end

    always_comb begin
        for (int b = 0; b < 8; b++) begin
            if (pm_oe_i[b]) begin
                pm_pad_o[b] = pm_val_i[b];
            end else if (ext_pm_en_i[b]) begin
                pm_pad_o[b] = ext_pm_i[b];
            end else if (pm_pull_i[b]) begin
                pm_pad_o[b] = ~pm_down_i[b];
            end else begin
                pm_pad_o[b] = float_q[b];
            end
        end
        for (int b = 0; b < 6; b++) begin
            if (pp_oe_i[b]) begin
                pp_pad_o[b] = pp_val_i[b];
            end else if (ext_pp_en_i[b]) begin
                pp_pad_o[b] = ext_pp_i[b];
            end else begin
                pp_pad_o[b] = float_q[b];
            end
        end
    end
endmodule

// ==== tb/ppcfg_port_cfg_bench.sv ====
// self-checking bench for the port M / port P pin configuration block
// assumes the pad model on the pins and an APB master run from this module
`timescale 1ns/1ps
module ppcfg_port_cfg_bench;
    import ppcfg_pkg::*;
    logic        clk = 1'b0;
    logic        reset = 1'b1;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic        pready, pslverr, iic_en = 1'b0, tx_en = 1'b0, tx = 1'b0, rx_en = 1'b0;
    logic [1:0]  iic_dir = 2'h0, iic_out = 2'h0, dac_en = 2'h0;
    logic [7:0]  pm_data = 8'h00, ext_pm = 8'h00;
    logic [5:0]  pwm_en = 6'h00, pwm = 6'h00, ext_pp = 6'h00;
    logic [7:0]  pm_pad, pm_o, pm_oe, pm_pu, pm_pd, pm_rd, pm_lvl;
    logic [5:0]  pp_pad, pp_o, pp_oe, pp_lvl;
    int          errors = 0;
    int          checks = 0;
    localparam logic [9:0] RW_IDX [7] = '{IDX_M_DIRECTION, IDX_M_REDUCED_DRIVE,
        IDX_M_PULL_ENABLE, IDX_M_PULL_POLARITY, IDX_M_OPEN_DRAIN, IDX_P_DATA, IDX_P_DIRECTION};
    localparam logic [7:0] RW_RST [7] = '{8'h00, 8'h00, 8'hF0, 8'h00, 8'h00, 8'h00, 8'h00};
    localparam logic [7:0] RW_MSK [7] = '{8'hFB, 8'hFB, 8'hFB, 8'hFB, 8'hFB, 8'h3F, 8'h3F};

    ppcfg_port_cfg ppcfg_port_cfg_i (.clk_i(clk), .reset_i(reset), .psel_i(psel),
        .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
        .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr), .port_m_data_i(pm_data),
        .iic_enable_i(iic_en), .iic_dir_i(iic_dir), .iic_out_i(iic_out),
        .sci_tx_enable_i(tx_en), .sci_tx_i(tx), .sci_rx_enable_i(rx_en),
        .dac_enable_i(dac_en), .pwm_enable_i(pwm_en), .pwm_i(pwm), .pm_pin_i(pm_pad),
        .pm_pin_o(pm_o), .pm_pin_oe_o(pm_oe), .pm_pull_enable_o(pm_pu),
        .pm_pull_down_o(pm_pd), .pm_reduced_drive_o(pm_rd), .pm_level_o(pm_lvl),
        .pp_pin_i(pp_pad), .pp_pin_o(pp_o), .pp_pin_oe_o(pp_oe), .pp_level_o(pp_lvl));
    ppcfg_pin_model ppcfg_pin_model_i (.clk_i(clk), .pm_val_i(pm_o), .pm_oe_i(pm_oe),
        .pm_pull_i(pm_pu), .pm_down_i(pm_pd), .pp_val_i(pp_o), .pp_oe_i(pp_oe),
        .ext_pm_i(ext_pm), .ext_pm_en_i(8'h00), .ext_pp_i(ext_pp), .ext_pp_en_i(6'h3F),
        .pm_pad_o(pm_pad), .pp_pad_o(pp_pad));

    initial begin
        forever #5 clk = ~clk;
    end

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            errors++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic test_done();
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic apb(input logic wr, input logic [9:0] idx, input logic [7:0] wd,
                       output logic [31:0] rd, output logic err);
        int n;
        n = 0;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= {idx, 2'b00};
        pwdata <= {24'h000000, wd};
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 20) begin
            errors++;
            test_done();
        end
    endtask

    task automatic wr(input logic [9:0] idx, input logic [7:0] d);
        logic [31:0] r;
        logic        e;
        apb(1'b1, idx, d, r, e);
        check("write error", {31'h0, e}, 32'h0);
    endtask

    task automatic rd(input string what, input logic [9:0] idx, input logic [31:0] exp);
        logic [31:0] r;
        logic        e;
        apb(1'b0, idx, 8'h00, r, e);
        check(what, r, exp);
    endtask

    task automatic settle(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    initial begin
        logic [31:0] r;
        logic        e;
        repeat (5) @(posedge clk);
        reset <= 1'b0;
        settle(1);
        check("pull after reset", pm_pu, 8'hF0);
        check("m oe after reset", pm_oe, 8'h00);
        check("p oe after reset", pp_oe, 6'h00);
        for (int i = 0; i < 7; i++) rd("reset value", RW_IDX[i], RW_RST[i]);
        check("m level pulled", pm_lvl, 8'hF0);
        wr(IDX_P_PIN_LEVEL, 8'hFF);
        rd("pin level", IDX_P_PIN_LEVEL, 32'h0);
        apb(1'b1, 10'h017, 8'hFF, r, e);
        check("unmapped error", {31'h0, e}, 32'h1);
        $display("reset test done");
        for (int i = 0; i < 7; i++) wr(RW_IDX[i], 8'hFF);
        for (int i = 0; i < 7; i++) rd("readback", RW_IDX[i], RW_MSK[i]);
        settle(2);
        check("od value", pm_o, 8'h00);
        check("od oe", pm_oe, 8'hFB);
        check("od pull", pm_pu, 8'hFB);
        check("od pull down", pm_pd, 8'h00);
        check("reduced", pm_rd, 8'hFB);
        check("p oe", pp_oe, 6'h3F);
        wr(IDX_M_OPEN_DRAIN, 8'h00);
        pm_data <= 8'hA5;
        settle(2);
        check("pp value", pm_o, 8'hA1);
        check("pp pull", pm_pu, 8'h00);
        wr(IDX_M_DIRECTION, 8'h00);
        settle(6);
        check("in oe", pm_oe, 8'h00);
        check("in pull", pm_pu, 8'hFB);
        check("in pull down", pm_pd, 8'hFB);
        check("in reduced", pm_rd, 8'h00);
        check("m level", pm_lvl, 8'h00);
        $display("port m gpio test done");
        wr(IDX_M_DIRECTION, 8'h30);
        wr(IDX_M_PULL_ENABLE, 8'h00);
        iic_en <= 1'b1;
        iic_dir <= 2'b11;
        iic_out <= 2'b10;
        tx_en <= 1'b1;
        rx_en <= 1'b1;
        dac_en <= 2'b11;
        settle(2);
        check("override oe", pm_oe, 8'h63);
        check("override value", pm_o & pm_oe, 8'h00);
        rd("direction kept", IDX_M_DIRECTION, 32'h30);
        wr(IDX_M_OPEN_DRAIN, 8'h20);
        tx <= 1'b1;
        iic_dir <= 2'b01;
        iic_out <= 2'b00;
        settle(2);
        check("serial od oe", pm_oe, 8'h43);
        rd("od kept", IDX_M_OPEN_DRAIN, 32'h20);
        iic_en <= 1'b0;
        tx_en <= 1'b0;
        rx_en <= 1'b0;
        dac_en <= 2'b00;
        wr(IDX_M_OPEN_DRAIN, 8'h00);
        settle(2);
        check("released oe", pm_oe, 8'h30);
        check("released value", pm_o & pm_oe, 8'h20);
        $display("override test done");
        wr(IDX_P_DIRECTION, 8'h0F);
        wr(IDX_P_DATA, 8'h3C);
        pwm_en <= 6'h30;
        pwm <= 6'h10;
        settle(6);
        check("pwm oe", pp_oe, 6'h3F);
        check("pwm value", pp_o, 6'h1C);
        rd("p data", IDX_P_DATA, 32'h1C);
        rd("p level", IDX_P_PIN_LEVEL, 32'h1C);
        pwm_en <= 6'h00;
        ext_pp <= 6'h2A;
        settle(6);
        check("pwm off oe", pp_oe, 6'h0F);
        check("p level out", pp_lvl, 6'h2C);
        rd("p data input", IDX_P_DATA, 32'h2C);
        $display("port p test done");
        reset <= 1'b1;
        settle(2);
        check("p oe in reset", pp_oe, 6'h00);
        check("pull in reset", pm_pu, 8'hF0);
        $display("second reset test done");
        test_done();
    end
endmodule
